// ### src/sbc_ctrl.sv
`timescale 1ns/1ns
module sbc_ctrl
    import sbc_pkg::*;
#(
    parameter int ENABLE_CYCLES = sbc_pkg::ENABLE_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Processor status and straps
    input wire logic [2:0] i_cpu_status_lines,
    input wire logic i_bus_mode_strap,
    input wire logic i_arbitration_enable_n,
    input wire logic i_command_gate,
    // Memory commands, active low, and their active-high output enable
    output logic o_mem_read_cmd_n,
    output logic o_early_mem_write_cmd_n,
    output logic o_mem_write_cmd_n,
    output logic o_mem_cmd_oe,
    // I/O and acknowledge commands, active low, and their active-high output enable
    output logic o_io_read_cmd_n,
    output logic o_io_write_cmd_n,
    output logic o_early_io_write_cmd_n,
    output logic o_irq_ack_cmd_n,
    output logic o_io_cmd_oe,
    // Transceiver and latch controls
    output logic o_xcvr_direction,
    output logic o_addr_latch_strobe,
    output logic o_data_xcvr_enable,
    output logic o_cascade_or_periph_data_enable
);
    import sbc_pkg::*;

    typedef struct packed {
        sbc_phase_t phase;
        logic [2:0] kind;
        logic mrd_n;
        logic amw_n;
        logic mwt_n;
        logic ior_n;
        logic iow_n;
        logic aiow_n;
        logic ack_n;
        logic mem_oe;
        logic io_oe;
        logic dir;
        logic ale;
        logic data_xcvr_enable;
        logic dual;
    } sbc_state_t;

    sbc_state_t state_q;
    sbc_state_t state_d;
    logic arb_ready;

    sbc_arb_timer #(
        .CYCLES(ENABLE_CYCLES)
    ) u_arb_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_active(!i_arbitration_enable_n),
        .o_done(arb_ready)
    );

    always_comb begin
        logic passive;
        logic gate;
        logic early;
        logic late;
        logic data_cyc;
        logic is_mem_rd;
        logic is_mem_wr;
        logic is_io_rd;
        logic is_io_wr;
        logic is_ack;
        logic is_read;
        logic io_kind;
        logic mem_ok;
        logic io_ok;
        passive = (i_cpu_status_lines == ST_PASSIVE);
        gate = i_command_gate;
        // Helpers start cleared so that no path reads a stale value.
        early = 1'h0;
        late = 1'h0;
        data_cyc = 1'h0;
        is_mem_rd = 1'h0;
        is_mem_wr = 1'h0;
        is_io_rd = 1'h0;
        is_io_wr = 1'h0;
        is_ack = 1'h0;
        is_read = 1'h0;
        io_kind = 1'h0;
        mem_ok = 1'h0;
        io_ok = 1'h0;
        state_d = state_q;
        state_d.ale = CTRL_OFF;
        // Phase sequencing on every rising edge of the system clock.
        unique case (state_q.phase)
            PH_IDLE: begin
                if (!passive) begin
                    state_d.phase = PH_LATCH;
                    state_d.kind = i_cpu_status_lines;
                    state_d.ale = !CTRL_OFF;
                end
            end
            PH_LATCH: begin
                state_d.phase = PH_EARLY;
            end
            PH_EARLY: begin
                state_d.phase = PH_LATE;
            end
            PH_LATE: begin
                state_d.phase = PH_LATE;
            end
        endcase
        // A return to passive ends the cycle from any phase.
        if (state_q.phase != PH_IDLE && passive) begin
            state_d.phase = PH_IDLE;
        end

        early = (state_d.phase == PH_EARLY) || (state_d.phase == PH_LATE);
        late = (state_d.phase == PH_LATE);
        is_ack = (state_d.kind == ST_IRQ_ACK);
        is_io_rd = (state_d.kind == ST_IO_READ);
        is_io_wr = (state_d.kind == ST_IO_WRITE);
        is_mem_rd = (state_d.kind == ST_CODE_FETCH) ||
                    (state_d.kind == ST_MEM_READ);
        is_mem_wr = (state_d.kind == ST_MEM_WRITE);
        is_read = is_ack || is_io_rd || is_mem_rd;
        io_kind = is_ack || is_io_rd || is_io_wr;
        data_cyc = early && (is_read || is_io_wr || is_mem_wr);

        // Commands: early group with the read timing, normal writes later.
        state_d.mrd_n = !(gate && early && is_mem_rd);
        state_d.amw_n = !(gate && early && is_mem_wr);
        state_d.mwt_n = !(gate && late && is_mem_wr);
        state_d.aiow_n = !(gate && early && is_io_wr);
        state_d.iow_n = !(gate && late && is_io_wr);
        state_d.ior_n = !(gate && early && is_io_rd);
        state_d.ack_n = !(gate && early && is_ack);

        // Drivers float until the arbitration delay has run out; in I/O bus mode the strap keeps the I/O drivers on.
        // Losing the grant floats the memory drivers at once, without waiting on the
        // timer; the I/O drivers float a cycle later, once the timer has cleared.
        mem_ok = arb_ready && !i_arbitration_enable_n;
        io_ok = i_bus_mode_strap || arb_ready;
        state_d.mem_oe = mem_ok;
        state_d.io_oe = io_ok;

        // Direction leans to transmit between cycles, as writes do.
        state_d.dir = !((state_d.phase != PH_IDLE) && is_read);

        // In I/O bus mode the I/O traffic moves to the second transceiver
        // set, so the system transceivers stay shut for it.
        if (i_bus_mode_strap) begin
            state_d.data_xcvr_enable = gate && data_cyc && !io_kind && mem_ok;
            state_d.dual = gate && data_cyc && io_kind;
        end else begin
            state_d.data_xcvr_enable = gate && data_cyc && mem_ok;
            state_d.dual = gate && (state_d.phase == PH_LATCH) &&
                           is_ack;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q.phase <= PH_IDLE;
            state_q.kind <= ST_PASSIVE;
            state_q.mrd_n <= CMD_INACTIVE_N;
            state_q.amw_n <= CMD_INACTIVE_N;
            state_q.mwt_n <= CMD_INACTIVE_N;
            state_q.ior_n <= CMD_INACTIVE_N;
            state_q.iow_n <= CMD_INACTIVE_N;
            state_q.aiow_n <= CMD_INACTIVE_N;
            state_q.ack_n <= CMD_INACTIVE_N;
            state_q.mem_oe <= CTRL_OFF;
            state_q.io_oe <= CTRL_OFF;
            state_q.dir <= DIR_IDLE;
            state_q.ale <= CTRL_OFF;
            state_q.data_xcvr_enable <= CTRL_OFF;
            state_q.dual <= CTRL_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_mem_read_cmd_n = state_q.mrd_n;
    assign o_early_mem_write_cmd_n = state_q.amw_n;
    assign o_mem_write_cmd_n = state_q.mwt_n;
    assign o_mem_cmd_oe = state_q.mem_oe;
    assign o_io_read_cmd_n = state_q.ior_n;
    assign o_io_write_cmd_n = state_q.iow_n;
    assign o_early_io_write_cmd_n = state_q.aiow_n;
    assign o_irq_ack_cmd_n = state_q.ack_n;
    assign o_io_cmd_oe = state_q.io_oe;
    assign o_xcvr_direction = state_q.dir;
    assign o_addr_latch_strobe = state_q.ale;
    assign o_data_xcvr_enable = state_q.data_xcvr_enable;
    assign o_cascade_or_periph_data_enable = state_q.dual;

    chk_ale_one_pulse: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        o_addr_latch_strobe |=> !o_addr_latch_strobe)
        else $error("Address strobe lasted more than one cycle.");

    chk_ale_each_cycle: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        ($past(i_cpu_status_lines) == ST_PASSIVE &&
         i_cpu_status_lines != ST_PASSIVE) |=> o_addr_latch_strobe)
        else $error("Bus cycle started without an address strobe.");

    chk_dir_write: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_addr_latch_strobe && state_q.kind == ST_IO_WRITE) |->
        o_xcvr_direction)
        else $error("Direction low during a write cycle.");

    chk_io_mode_oe: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_bus_mode_strap |=> o_io_cmd_oe)
        else $error("I/O commands floated in I/O bus mode.");

    chk_arb_delay: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(i_arbitration_enable_n) ##0 !i_arbitration_enable_n [*7]
        |=> o_mem_cmd_oe)
        else $error("Memory commands not enabled after the delay.");

    chk_arb_not_early: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(i_arbitration_enable_n) |-> !o_mem_cmd_oe [*3])
        else $error("Memory commands enabled too soon.");

    chk_arb_float: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_arbitration_enable_n |=> !o_mem_cmd_oe)
        else $error("Memory commands driven without arbitration.");

    chk_gate_quiet: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !i_command_gate |=> (o_mem_read_cmd_n && o_mem_write_cmd_n &&
        o_early_mem_write_cmd_n && o_io_read_cmd_n && o_io_write_cmd_n &&
        o_early_io_write_cmd_n && o_irq_ack_cmd_n && !o_data_xcvr_enable &&
        !o_cascade_or_periph_data_enable))
        else $error("Output active while the command gate is low.");

    chk_write_order: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!o_early_mem_write_cmd_n && o_mem_write_cmd_n) |=>
        (!o_mem_write_cmd_n || o_early_mem_write_cmd_n))
        else $error("Normal memory write did not follow the early one.");

    chk_passive_end: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_cpu_status_lines == ST_PASSIVE) |=> (o_mem_read_cmd_n &&
        o_early_mem_write_cmd_n && o_mem_write_cmd_n && o_io_read_cmd_n &&
        o_io_write_cmd_n && o_early_io_write_cmd_n && o_irq_ack_cmd_n))
        else $error("Command still active after passive status.");

    chk_dir_read: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!o_mem_read_cmd_n || !o_io_read_cmd_n || !o_irq_ack_cmd_n) |->
        !o_xcvr_direction)
        else $error("Direction high during a read command.");

    chk_dir_writes: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!o_early_mem_write_cmd_n || !o_early_io_write_cmd_n) |->
        o_xcvr_direction)
        else $error("Direction low during a write command.");

    chk_read_early: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_addr_latch_strobe && i_command_gate &&
         i_cpu_status_lines != ST_PASSIVE &&
         (state_q.kind == ST_MEM_READ || state_q.kind == ST_CODE_FETCH))
        |=> !o_mem_read_cmd_n)
        else $error("Memory read command not issued after the strobe.");

    chk_mem_write_early: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_addr_latch_strobe && i_command_gate &&
         i_cpu_status_lines != ST_PASSIVE &&
         state_q.kind == ST_MEM_WRITE) |=>
        (!o_early_mem_write_cmd_n && o_mem_write_cmd_n))
        else $error("Memory write commands out of step.");

    chk_io_write_early: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_addr_latch_strobe && i_command_gate &&
         i_cpu_status_lines != ST_PASSIVE &&
         state_q.kind == ST_IO_WRITE) |=>
        (!o_early_io_write_cmd_n && o_io_write_cmd_n))
        else $error("I/O write commands out of step.");

    chk_io_write_pair: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        !o_io_write_cmd_n |-> !o_early_io_write_cmd_n)
        else $error("Normal I/O write without the early one.");

    chk_halt_quiet: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (state_q.kind == ST_HALT) |-> (o_mem_read_cmd_n &&
        o_early_mem_write_cmd_n && o_mem_write_cmd_n && o_io_read_cmd_n &&
        o_io_write_cmd_n && o_early_io_write_cmd_n && o_irq_ack_cmd_n))
        else $error("Command issued during a halt cycle.");

    chk_cascade_ack: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        (!$past(i_bus_mode_strap) && o_cascade_or_periph_data_enable) |->
        (o_addr_latch_strobe && state_q.kind == ST_IRQ_ACK))
        else $error("Cascade enable outside an acknowledge strobe.");

    chk_periph_enable: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        ($past(i_bus_mode_strap) && (!o_io_read_cmd_n ||
         !o_early_io_write_cmd_n || !o_irq_ack_cmd_n)) |->
        (o_cascade_or_periph_data_enable && !o_data_xcvr_enable))
        else $error("I/O bus transfer without the peripheral enable.");

    chk_den_memory: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        ((!o_mem_read_cmd_n || !o_early_mem_write_cmd_n) &&
         o_mem_cmd_oe) |-> o_data_xcvr_enable)
        else $error("Data enable low during a memory transfer.");

endmodule

// ### src/sbc_pkg.sv
package sbc_pkg;

    localparam logic [2:0] ST_IRQ_ACK = 3'h0;
    localparam logic [2:0] ST_IO_READ = 3'h1;
    localparam logic [2:0] ST_IO_WRITE = 3'h2;
    localparam logic [2:0] ST_HALT = 3'h3;
    localparam logic [2:0] ST_CODE_FETCH = 3'h4;
    localparam logic [2:0] ST_MEM_READ = 3'h5;
    localparam logic [2:0] ST_MEM_WRITE = 3'h6;
    localparam logic [2:0] ST_PASSIVE = 3'h7;

    localparam int CLK_PERIOD_NS = 20;
    localparam int ENABLE_DELAY_NS = 105;
    localparam int ENABLE_DELAY_CYCLES =
        (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic CMD_INACTIVE_N = 1'h1;
    localparam logic DIR_IDLE = 1'h1;
    localparam logic CTRL_OFF = 1'h0;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LATCH = 2'b01,
        PH_EARLY = 2'b10,
        PH_LATE = 2'b11
    } sbc_phase_t;

endpackage

// ### src/sbc_arb_timer.sv
`timescale 1ns/1ns
module sbc_arb_timer
    import sbc_pkg::*;
#(
    parameter int CYCLES = sbc_pkg::ENABLE_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Level to be timed and its qualified result
    input wire logic i_active,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } sbc_tmr_state_t;

    sbc_tmr_state_t state_q;
    sbc_tmr_state_t state_d;

    // The count saturates, so a long grant never wraps back to disabled.
    always_comb begin
        state_d = state_q;
        if (!i_active) begin
            state_d.cnt = '0;
        end else if (state_q.cnt != CW'(CYCLES)) begin
            state_d.cnt = state_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_done = (state_q.cnt == CW'(CYCLES));

endmodule

// ### tb/sbc_cpu_model.sv
`timescale 1ns/1ns
module sbc_cpu_model
    import sbc_pkg::*;
(
    // Clock
    input wire logic i_sys_clk,
    // Status and arbitration toward the controller
    output logic [2:0] o_status,
    output logic o_arb_n
);
    initial begin
        o_status = ST_PASSIVE;
        o_arb_n = 1'h1;
    end

    task automatic begin_cycle(input logic [2:0] code);
        @(negedge i_sys_clk);
        o_status = code;
    endtask

    // The processor parks the lines high between cycles.
    task automatic end_cycle();
        @(negedge i_sys_clk);
        o_status = ST_PASSIVE;
    endtask

    task automatic grant(input logic req_n);
        @(negedge i_sys_clk);
        o_arb_n = req_n;
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
module tb;
    import sbc_pkg::*;
    logic i_sys_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_bus_mode_strap = 1'h0;
    logic i_command_gate = 1'h1;
    logic [2:0] st;
    logic arb_n;
    logic mrd, amw, mw, mem_oe, io_read_cmd, iow, aiow, irq_ack_cmd, io_oe;
    logic dir, ale, data_xcvr_enable, dual;
    wire [6:0] cmds = {mrd, amw, mw, io_read_cmd, iow, aiow, irq_ack_cmd};
    wire [3:0] ctl = {ale, data_xcvr_enable, dual, dir};
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;

    always #10 i_sys_clk = ~i_sys_clk;

    sbc_cpu_model sbc_cpu_model_i (
        .i_sys_clk(i_sys_clk),
        .o_status(st),
        .o_arb_n(arb_n)
    );

    sbc_ctrl sbc_ctrl_i (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_cpu_status_lines(st),
        .i_bus_mode_strap(i_bus_mode_strap),
        .i_arbitration_enable_n(arb_n),
        .i_command_gate(i_command_gate),
        .o_mem_read_cmd_n(mrd),
        .o_early_mem_write_cmd_n(amw),
        .o_mem_write_cmd_n(mw),
        .o_mem_cmd_oe(mem_oe),
        .o_io_read_cmd_n(io_read_cmd),
        .o_io_write_cmd_n(iow),
        .o_early_io_write_cmd_n(aiow),
        .o_irq_ack_cmd_n(irq_ack_cmd),
        .o_io_cmd_oe(io_oe),
        .o_xcvr_direction(dir),
        .o_addr_latch_strobe(ale),
        .o_data_xcvr_enable(data_xcvr_enable),
        .o_cascade_or_periph_data_enable(dual)
    );

    task automatic summarize();
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    // One whole bus cycle; the mask hides controls left open for a code.
    task automatic run(input logic [2:0] code, input logic [6:0] e1,
                       input logic [6:0] e2, input logic [3:0] k1,
                       input logic [3:0] k2, input logic [3:0] m);
        sbc_cpu_model_i.begin_cycle(code);
        ticks(1);
        chk({4'h0, ctl & m}, {4'h0, k1 & m});
        ticks(1);
        chk({1'h0, cmds}, {1'h0, e1});
        chk({4'h0, ctl & m}, {4'h0, k2 & m});
        ticks(1);
        chk({1'h0, cmds}, {1'h0, e2});
        sbc_cpu_model_i.end_cycle();
        ticks(2);
        chk({cmds, data_xcvr_enable}, {7'h7F, 1'h0});
    endtask

    task automatic t_reset();
        ticks(2);
        i_rst = 1'h0;
        chk({cmds, mem_oe}, {7'h7F, 1'h0});
        chk({3'h0, io_oe, ctl}, {3'h0, 1'h0, 4'h1});
    endtask

    task automatic t_arbitration();
        sbc_cpu_model_i.grant(1'h0);
        ticks(6);
        chk({6'h0, mem_oe, io_oe}, 8'h00);
        ticks(1);
        chk({6'h0, mem_oe, io_oe}, 8'h03);
    endtask

    task automatic t_system_cycles();
        run(3'h0, 7'h7E, 7'h7E, 4'hA, 4'h4, 4'hF);
        run(3'h1, 7'h77, 7'h77, 4'h8, 4'h4, 4'hF);
        run(3'h2, 7'h7D, 7'h79, 4'h9, 4'h5, 4'hF);
        run(3'h3, 7'h7F, 7'h7F, 4'h9, 4'h1, 4'hF);
        run(3'h4, 7'h3F, 7'h3F, 4'h8, 4'h4, 4'hF);
        run(3'h5, 7'h3F, 7'h3F, 4'h8, 4'h4, 4'hF);
        run(3'h6, 7'h5F, 7'h4F, 4'h9, 4'h5, 4'hF);
    endtask

    task automatic t_gate();
        @(negedge i_sys_clk);
        i_command_gate = 1'h0;
        run(3'h5, 7'h7F, 7'h7F, 4'h8, 4'h0, 4'hF);
        @(negedge i_sys_clk);
        i_command_gate = 1'h1;
    endtask

    // With the grant gone only the strap keeps the I/O commands driven.
    task automatic t_io_mode();
        sbc_cpu_model_i.grant(1'h1);
        ticks(2);
        chk({6'h0, mem_oe, io_oe}, 8'h00);
        i_bus_mode_strap = 1'h1;
        ticks(2);
        chk({6'h0, mem_oe, io_oe}, 8'h01);
        run(3'h1, 7'h77, 7'h77, 4'h8, 4'h2, 4'hF);
        run(3'h2, 7'h7D, 7'h79, 4'h9, 4'h3, 4'hF);
        run(3'h0, 7'h7E, 7'h7E, 4'h8, 4'h2, 4'hF);
        run(3'h6, 7'h5F, 7'h4F, 4'h9, 4'h1, 4'hF);
        chk({6'h0, mem_oe, io_oe}, 8'h01);
    endtask

    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        t_reset();
        t_arbitration();
        t_system_cycles();
        t_gate();
        t_io_mode();
        summarize();
    end
endmodule
